// [common/bppsr_map.vh]
// Register offsets, field positions and codes for the burst preamble and page select registers
`ifndef BPPSR_MAP_VH
`define BPPSR_MAP_VH
// ==========================================
// Register offsets (7-bit host address)
`define BPPSR_OFS_TYPE_HIGH    7'h29
`define BPPSR_OFS_TYPE_LOW     7'h2a
`define BPPSR_OFS_LEN_HIGH     7'h2b
`define BPPSR_OFS_LEN_LOW      7'h2c
`define BPPSR_OFS_PAGE_SEL     7'h7f
// ==========================================
// Page select codes
`define BPPSR_PAGE_CTRL        2'h0
`define BPPSR_PAGE_RX_BUF      2'h1
`define BPPSR_PAGE_TX_BUF      2'h2
`define BPPSR_PAGE_RSVD        2'h3
`define BPPSR_PAGE_RESET       2'h0
// ==========================================
// Data-type preamble fields
`define BPPSR_TYPE_CODE_MSB    4
`define BPPSR_TYPE_CODE_LSB    0
`define BPPSR_ERR_BIT          7
`define BPPSR_DEP_MSB          12
`define BPPSR_DEP_LSB          8
// Data-type codes
`define BPPSR_DT_NULL          5'h00
`define BPPSR_DT_RSVD_A        5'h02
`define BPPSR_DT_PAUSE         5'h03
`define BPPSR_DT_MPEG_FIRST    5'h04
`define BPPSR_DT_AAC           5'h07
`define BPPSR_DT_MPEG_LAST     5'h09
`define BPPSR_DT_RSVD_B        5'h0a
`define BPPSR_DT_RSVD_HI       5'h10
// ==========================================
// Read data for unmapped or reserved locations
`define BPPSR_ZERO_BYTE        8'h00
`define BPPSR_ZERO_WORD        16'h0000
`endif

// [hw/bppsr_regs.v]
// Burst preamble status registers and register page selection for the serial host port
//
// Overview of operation
// RULE1: Type code in low byte bits 4:0
// RULE2: Codes 04-09 mark the MPEG family
// RULE3: Error bit flags possibly corrupt payload
// RULE4: Type-dependent bits 12:8 pass through raw
// RULE5: Length high byte at offset 2B
// RULE6: Length low byte at offset 2C
// RULE7: Page field routes host to page
// RULE8: Page resets to control page
// RULE9: Page register decoded on every page
// RULE10: Page register bits 7:2 read zero
// RULE11: Selected page steers reads and writes
// RULE12: Type high byte at offset 29
// RULE13: Length in bits, type identifies data
// RULE14: Registers updated from receiver decode
// RULE15: Writes to status registers are ignored
`timescale 1ns/100ps
`include "bppsr_map.vh"
module bppsr_regs #(
  parameter AW = 7,   // Host address width
  parameter DW = 8    // Host data width
) (
  input  wire          ref_clk,
  input  wire          rst_n,
  // Host port access, already in this clock domain
  input  wire          host_wr,
  input  wire          host_rd,
  input  wire [AW-1:0] host_addr,
  input  wire [DW-1:0] host_wdata,
  output reg  [DW-1:0] host_rdata,
  output reg           host_rvalid,
  // Receiver preamble decode, from the receiver clock domain
  input  wire          rx_pre_valid,
  input  wire [15:0]   rx_type_word,
  input  wire [15:0]   rx_len_word,
  // Routed accesses to the other pages
  output wire [1:0]    page_sel,
  output wire          page_select_high_bit,
  output wire          page_select_low_bit,
  output wire          page_ctrl_sel,
  output wire          page_rx_sel,
  output wire          page_tx_sel,
  output wire          buf_wr,
  output wire          buf_rd,
  output wire [AW-1:0] buf_addr,
  output wire [DW-1:0] buf_wdata,
  input  wire [DW-1:0] buf_rdata,
  // Decoded type classification
  output reg           type_is_null,
  output reg           type_is_pause,
  output reg           type_is_mpeg,
  output reg           type_is_aac,
  output reg           type_reserved,
  output reg           payload_err
);
  // ==========================================
  // Reset release
  reg       rst_meta;     // First reset stage
  reg       rst_sync_n;   // Reset used by the rest of the block

  // Release reset through two flops, assert at once
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ==========================================
  // Receiver crossing
  wire [32:0] rx_sync;     // Synchronised valid and words
  reg         vld_d;       // Last synchronised valid, for edge detect
  reg         vld_d2;      // One cycle older, so the words are taken a cycle after valid
  reg  [15:0] type_word;   // Held data-type preamble
  reg  [15:0] len_word;    // Held burst-length preamble (in bits)

  // Words must be stable while valid is high; only valid's rise loads them
  bppsr_sync #(
    .WIDTH (33)
  ) u_sync (
    .clk   (ref_clk),
    .rst_n (rst_sync_n),
    .din   ({rx_pre_valid, rx_type_word, rx_len_word}),
    .dout  (rx_sync)
  );

  // RULE14: receiver load
  // RULE13: words kept as received
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      vld_d     <= 1'b0;
      vld_d2    <= 1'b0;
      type_word <= `BPPSR_ZERO_WORD;
      len_word  <= `BPPSR_ZERO_WORD;
    end else begin
      vld_d  <= rx_sync[32];
      vld_d2 <= vld_d;
      // Words are taken one cycle after the synchronised rise: they were sampled an edge
      // after valid, so a word that changes together with valid is never caught mid-flight
      if (vld_d && !vld_d2) begin
        type_word <= rx_sync[31:16];
        len_word  <= rx_sync[15:0];
      end
    end
  end

  // ==========================================
  // Type classification
  function in_range;
    input [4:0] code;
    input [4:0] lo;
    input [4:0] hi;
    begin
      in_range = (code >= lo) && (code <= hi);
    end
  endfunction

  wire [4:0] type_code = type_word[`BPPSR_TYPE_CODE_MSB:`BPPSR_TYPE_CODE_LSB];

  // RULE1: code decode
  // RULE2: MPEG family decode
  // RULE3: error flag
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      type_is_null  <= 1'b0;
      type_is_pause <= 1'b0;
      type_is_mpeg  <= 1'b0;
      type_is_aac   <= 1'b0;
      type_reserved <= 1'b0;
      payload_err   <= 1'b0;
    end else begin
      type_is_null  <= (type_code == `BPPSR_DT_NULL);
      type_is_pause <= (type_code == `BPPSR_DT_PAUSE);
      type_is_mpeg  <= in_range(type_code, `BPPSR_DT_MPEG_FIRST, `BPPSR_DT_MPEG_LAST);
      type_is_aac   <= (type_code == `BPPSR_DT_AAC);
      type_reserved <= (type_code == `BPPSR_DT_RSVD_A) || (type_code == `BPPSR_DT_RSVD_B) ||
                       (type_code >= `BPPSR_DT_RSVD_HI);
      payload_err   <= type_word[`BPPSR_ERR_BIT];
    end
  end

  // ==========================================
  // Page selection
  reg  [1:0] page;         // Current page
  wire       hit_page = (host_addr == `BPPSR_OFS_PAGE_SEL);

  // RULE9: decoded on all pages
  // RULE8: reset to control page
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      page <= `BPPSR_PAGE_RESET;
    end else if (host_wr && hit_page) begin
      page <= host_wdata[1:0];
    end
  end

  // RULE7: page routing
  assign page_sel             = page;
  assign page_select_high_bit = page[1];
  assign page_select_low_bit  = page[0];
  assign page_ctrl_sel        = (page == `BPPSR_PAGE_CTRL);
  assign page_rx_sel          = (page == `BPPSR_PAGE_RX_BUF);
  assign page_tx_sel          = (page == `BPPSR_PAGE_TX_BUF);

  // RULE11: page steers both directions; reserved page reaches nothing
  // RULE15: status writes dropped, page 0 writes go nowhere here
  assign buf_wr    = host_wr && !hit_page && (page_rx_sel || page_tx_sel);
  assign buf_rd    = host_rd && !hit_page && (page_rx_sel || page_tx_sel);
  assign buf_addr  = host_addr;
  assign buf_wdata = host_wdata;

  // ==========================================
  // Read data mux, one cycle after the read strobe
  reg [DW-1:0] next_rdata;

  // Address decode with page qualification
  always @* begin
    next_rdata = `BPPSR_ZERO_BYTE;
    if (hit_page) begin
      // RULE10: upper bits zero
      next_rdata = {6'h00, page};
    end else if (page_rx_sel || page_tx_sel) begin
      next_rdata = buf_rdata;
    end else if (page_ctrl_sel && host_addr == `BPPSR_OFS_TYPE_HIGH) begin
      // RULE12: type high byte
      // RULE4: bits 12:8 raw
      next_rdata = type_word[15:8];
    end else if (page_ctrl_sel && host_addr == `BPPSR_OFS_TYPE_LOW) begin
      next_rdata = type_word[7:0];
    end else if (page_ctrl_sel && host_addr == `BPPSR_OFS_LEN_HIGH) begin
      // RULE5: length high
      next_rdata = len_word[15:8];
    end else if (page_ctrl_sel && host_addr == `BPPSR_OFS_LEN_LOW) begin
      // RULE6: length low
      next_rdata = len_word[7:0];
    end
  end

  // Registered read answer
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      host_rdata  <= `BPPSR_ZERO_BYTE;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      if (host_rd) begin
        host_rdata <= next_rdata;
      end
    end
  end
endmodule

// [hw/bppsr_sync.v]
// Two-flop synchroniser for a bus of levels arriving from outside the clock domain
`timescale 1ns/100ps
module bppsr_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  // ==========================================
  // Synchroniser stages
  reg [WIDTH-1:0] meta;  // First stage, read only by the second

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// [sim/bppsr_props.sv]
// Checker for the page selection and preamble status ports
`timescale 1ns/100ps
module bppsr_props (
  input wire       ref_clk,
  input wire       rst_n,
  input wire       host_wr,
  input wire       host_rd,
  input wire [6:0] host_addr,
  input wire [7:0] host_wdata,
  input wire [7:0] host_rdata,
  input wire [1:0] page_sel,
  input wire       page_select_high_bit,
  input wire       page_select_low_bit,
  input wire       page_ctrl_sel,
  input wire       page_rx_sel,
  input wire       page_tx_sel,
  input wire       buf_wr,
  input wire [7:0] buf_rdata,
  input wire       type_is_aac,
  input wire       type_is_mpeg,
  input wire       payload_err
);
  // ====
  // One domain, so clock and disable are given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire pg_wr = host_wr && host_addr == 7'h7f;
  wire pg_rd = host_rd && host_addr == 7'h7f;
  property p_rst; $rose(rst_n) |-> page_ctrl_sel && page_sel == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("page not control after reset");
  property p_pgwr; pg_wr |=> {6'h0, page_sel} == ($past(host_wdata) & 8'h03); endproperty
  a_pgwr: assert property (p_pgwr) else $error("page write lost");
  property p_pgrd; pg_rd |=> host_rdata == {6'h0, $past(page_sel)}; endproperty
  a_pgrd: assert property (p_pgrd) else $error("page read wrong");
  property p_dec;
    page_ctrl_sel == (page_sel == 2'h0) && page_rx_sel == (page_sel == 2'h1) && page_tx_sel == (page_sel == 2'h2)
      && page_select_high_bit == page_sel[1] && page_select_low_bit == page_sel[0];
  endproperty
  a_dec: assert property (p_dec) else $error("page decode wrong");
  property p_bufwr; buf_wr == (host_wr && !pg_wr && (page_rx_sel || page_tx_sel)); endproperty
  a_bufwr: assert property (p_bufwr) else $error("buffer write misrouted");
  property p_bufrd; host_rd && !pg_rd && (page_rx_sel || page_tx_sel) |=> host_rdata == $past(buf_rdata); endproperty
  a_bufrd: assert property (p_bufrd) else $error("buffer read misrouted");
  property p_aac; type_is_aac |-> type_is_mpeg; endproperty
  a_aac: assert property (p_aac) else $error("transport code outside family");
  property p_err; host_rd && page_ctrl_sel && host_addr == 7'h2a |=> host_rdata[7] == payload_err; endproperty
  a_err: assert property (p_err) else $error("error flag mismatch");
  c_pg: cover property (pg_wr && host_wdata[1:0] == 2'h2);
  c_mpeg: cover property (type_is_mpeg);
  c_err: cover property (payload_err);
endmodule
bind bppsr_regs bppsr_props u_props (.ref_clk, .rst_n, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata,
  .page_sel, .page_select_high_bit, .page_select_low_bit, .page_ctrl_sel, .page_rx_sel, .page_tx_sel,
  .buf_wr, .buf_rdata, .type_is_aac, .type_is_mpeg, .payload_err);

// [sim/bppsr_rx_src.sv]
// Receiver preamble source and page buffer model
`timescale 1ns/100ps
module bppsr_rx_src (
  input  wire        ref_clk,
  input  wire [6:0]  buf_addr,
  input  wire        buf_wr,
  input  wire        buf_rd,
  input  wire [7:0]  buf_wdata,
  input  wire        page_tx_sel,
  output reg         rx_pre_valid,
  output reg  [15:0] rx_type_word,
  output reg  [15:0] rx_len_word,
  output wire [7:0]  buf_rdata
);
  reg [7:0] wr_cnt = 8'h00;   // Buffer writes seen
  reg [7:0] rd_cnt = 8'h00;   // Buffer reads seen
  reg [7:0] last_wr = 8'h00;  // Last byte written to a buffer page
  // Buffer data follows address and buffer page, so a stale or misrouted byte cannot pass
  assign buf_rdata = {page_tx_sel, ~buf_addr};
  // Count the strobes that reach the buffer pages
  always @(posedge ref_clk) begin
    if (buf_wr) begin
      wr_cnt <= wr_cnt + 8'h01;
      last_wr <= buf_wdata;
    end
    if (buf_rd)
      rd_cnt <= rd_cnt + 8'h01;
  end
  initial begin
    rx_pre_valid = 1'b0;
    rx_type_word = 16'h0000;
    rx_len_word = 16'h0000;
  end
  task load(input [15:0] t, input [15:0] l);
    @(negedge ref_clk);
    rx_type_word = t;
    rx_len_word = l;
    rx_pre_valid = 1'b1;
    repeat (4) @(negedge ref_clk);
    rx_pre_valid = 1'b0;
    // Words are not held once valid drops
    rx_type_word = ~t;
    rx_len_word = ~l;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule

// [sim/tb_burst_preamble_page_select_regs.sv]
// Self-checking bench for the preamble status and page select registers
`timescale 1ns/100ps
module tb_burst_preamble_page_select_regs;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         host_wr = 1'b0;
  reg         host_rd = 1'b0;
  reg  [6:0]  host_addr = 7'h00;
  reg  [7:0]  host_wdata = 8'h00;
  wire [7:0]  host_rdata, buf_rdata, buf_wdata;
  wire [6:0]  buf_addr;
  wire [15:0] tw, lw;
  wire        host_rvalid, rv, f_nul, f_pau, f_mpg, f_aac, f_rsv, f_err;
  wire        bw, br, ptx;
  integer     error_cnt = 0;
  integer     compares = 0;
  always #25 ref_clk = ~ref_clk;
  bppsr_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid), .rx_pre_valid(rv),
    .rx_type_word(tw), .rx_len_word(lw), .page_sel(), .page_select_high_bit(), .page_select_low_bit(),
    .page_ctrl_sel(), .page_rx_sel(), .page_tx_sel(ptx), .buf_wr(bw), .buf_rd(br), .buf_addr(buf_addr),
    .buf_wdata(buf_wdata), .buf_rdata(buf_rdata), .type_is_null(f_nul), .type_is_pause(f_pau),
    .type_is_mpeg(f_mpg), .type_is_aac(f_aac), .type_reserved(f_rsv), .payload_err(f_err));
  bppsr_rx_src P (.ref_clk(ref_clk), .buf_addr(buf_addr), .buf_wr(bw), .buf_rd(br), .buf_wdata(buf_wdata),
    .page_tx_sel(ptx), .rx_pre_valid(rv), .rx_type_word(tw),
    .rx_len_word(lw), .buf_rdata(buf_rdata));
  // ====
  // Byte compare and host accesses, driven on the falling edge
  task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
    compares = compares + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("BAD %0s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    @(negedge ref_clk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge ref_clk);
    host_wr = 1'b0;
  endtask
  task rd(input [6:0] a, input [7:0] e);
    @(negedge ref_clk);
    host_rd = 1'b1;
    host_addr = a;
    @(negedge ref_clk);
    host_rd = 1'b0;
    chk("rvalid", 8'h01, {7'h0, host_rvalid});
    chk("rdata", e, host_rdata);
  endtask
  // ====
  // Every page code; pages 1 and 2 answer from the buffer model
  task t_pages;
    integer p;
    reg [7:0] nw, nr;
    nw = 8'h00;
    nr = 8'h00;
    rd(7'h7f, 8'h00);
    for (p = 0; p < 4; p = p + 1) begin
      wr(7'h7f, 8'hfc | p[7:0]);
      rd(7'h7f, p[7:0]);
      rd(7'h2b, (p == 1) ? 8'h54 : (p == 2) ? 8'hd4 : 8'h00);
      wr(7'h2b, 8'h10 | p[7:0]);
      if (p == 1 || p == 2) begin
        nw = nw + 8'h01;
        nr = nr + 8'h01;
        chk("bufdat", 8'h10 | p[7:0], P.last_wr);
      end
      chk("bufwr", nw, P.wr_cnt);
      chk("bufrd", nr, P.rd_cnt);
    end
    wr(7'h7f, 8'h00);
    $display("test pages done");
  endtask
  // ====
  // Type codes across every class, with written bytes that must not stick
  task t_pre;
    reg [49:0] cl;
    reg [15:0] t, l;
    reg [4:0]  c;
    integer    i;
    cl = {5'h00, 5'h02, 5'h03, 5'h04, 5'h07, 5'h09, 5'h0a, 5'h0b, 5'h10, 5'h1f};
    for (i = 0; i < 10; i = i + 1) begin
      c = cl[5*i +: 5];
      t = {3'h5, c ^ 5'h15, i[0], 2'h0, c};
      l = {c, 3'h6, ~c, i[2:0]};
      P.load(t, l);
      wr(7'h2b, ~l[15:8]);
      rd(7'h29, t[15:8]);
      rd(7'h2a, t[7:0]);
      rd(7'h2b, l[15:8]);
      rd(7'h2c, l[7:0]);
      chk("flags", {2'h0, c == 5'h00, c == 5'h03, c >= 5'h04 && c <= 5'h09, c == 5'h07,
        c == 5'h02 || c == 5'h0a || c >= 5'h10, t[7]}, {2'h0, f_nul, f_pau, f_mpg, f_aac, f_rsv, f_err});
    end
    $display("test preamble done");
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_pages;
    t_pre;
    conclude;
  end
  // Watchdog, several times the expected run
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    conclude;
  end
endmodule
